/* timer_array_pkg.sv */
package timer_array_pkg;

  // Number of channels and counter width.
  localparam int unsigned NUM_CHANNELS  = 4;
  localparam int unsigned COUNTER_WIDTH = 32;

  // Largest power-of-two exponent of the prescaler (divide by 2^15).
  localparam int unsigned PRESCALE_MAX_EXP = 15;
  localparam int unsigned PRESCALE_EXP_W   = 4;

  // Width of the non-power-of-two divider for the fourth count clock.
  localparam int unsigned FINE_DIV_WIDTH = 8;

  // Reset values.
  localparam logic [31:0] COUNTER_RESET_VALUE = 32'h0000_0000;
  localparam logic [31:0] DATA_RESET_VALUE    = 32'h0000_0000;
  localparam logic        OUTPUT_RESET_LEVEL  = 1'b0;

  // Count clock source selection per channel.
  typedef enum logic [2:0] {
    SRC_CK0        = 3'b000,
    SRC_CK1        = 3'b001,
    SRC_CK2        = 3'b010,
    SRC_CK3        = 3'b011,
    SRC_MASTER_IRQ = 3'b100,
    SRC_INPUT_EDGE = 3'b101
  } count_src_t;

  // Start trigger selection per channel.
  typedef enum logic [1:0] {
    TRIG_SOFTWARE   = 2'b00,
    TRIG_INPUT_EDGE = 2'b01,
    TRIG_MASTER_IRQ = 2'b10
  } start_trig_t;

  // Operation mode: data value is reload start value or compare value.
  typedef enum logic [0:0] {
    MODE_INTERVAL_DOWN = 1'b0,
    MODE_COMPARE_UP    = 1'b1
  } op_mode_t;

  // Channel state machine.
  typedef enum logic [1:0] {
    CH_STOPPED  = 2'b00,
    CH_WAITING  = 2'b01,
    CH_COUNTING = 2'b10
  } ch_state_t;

  // Static configuration of one channel.
  typedef struct packed {
    op_mode_t    mode;
    count_src_t  clk_src;
    start_trig_t trig;
    logic        is_slave;
    logic        sync_output;
    logic [31:0] data_value;
  } channel_cfg_t;

  // Prescaler configuration.
  typedef struct packed {
    logic [PRESCALE_EXP_W-1:0] exp0;
    logic [PRESCALE_EXP_W-1:0] exp1;
    logic [PRESCALE_EXP_W-1:0] exp2;
    logic [PRESCALE_EXP_W-1:0] exp3;
    logic [FINE_DIV_WIDTH-1:0] fine_div;
  } prescaler_cfg_t;

endpackage

/* timer_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler
  import timer_array_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  input  wire logic           ce_i,
  input  wire prescaler_cfg_t cfg_i,
  output logic [3:0]          tick_o
);

  // Free running divider chain; bit k toggles every 2^k cycles and rises every 2^(k+1).
  logic [PRESCALE_MAX_EXP-1:0] div_cnt;
  // Delayed copy for rising-edge detection of each divider bit.
  logic [PRESCALE_MAX_EXP-1:0] div_prev;
  // Counter for the fine non-power-of-two divider.
  logic [7:0]                  fine_cnt;
  // Raw power-of-two ticks before the fine divider.
  logic [3:0]                  raw_tick;

  // Returns a one-cycle tick at a rate of clk / 2^exp.
  function automatic logic pow2_tick(input logic [3:0] exp,
                                     input logic [PRESCALE_MAX_EXP-1:0] cnt,
                                     input logic [PRESCALE_MAX_EXP-1:0] prev);
    logic r;
    r = 1'b1;
    if (exp != 4'h0) begin
      r = cnt[exp-4'h1] & ~prev[exp-4'h1];
    end
    return r;
  endfunction

  // The divider chain runs from the peripheral clock only.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt  <= '0;
      div_prev <= '0;
    end else if (ce_i) begin
      div_cnt  <= div_cnt + 15'h0001;
      div_prev <= div_cnt;
    end
  end

  // Power-of-two selection for all four clocks.
  always_comb begin
    raw_tick[0] = pow2_tick(cfg_i.exp0, div_cnt, div_prev);
    raw_tick[1] = pow2_tick(cfg_i.exp1, div_cnt, div_prev);
    raw_tick[2] = pow2_tick(cfg_i.exp2, div_cnt, div_prev);
    raw_tick[3] = pow2_tick(cfg_i.exp3, div_cnt, div_prev);
  end

  // Fine divider: passes one of every fine_div+1 raw ticks of clock 3.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fine_cnt <= 8'h00;
    end else if (ce_i && raw_tick[3]) begin
      if (fine_cnt >= cfg_i.fine_div) begin
        fine_cnt <= 8'h00;
      end else begin
        fine_cnt <= fine_cnt + 8'h01;
      end
    end
  end

  // Ticks are suppressed while the clock enable is low.
  assign tick_o = {raw_tick[3] & (fine_cnt >= cfg_i.fine_div), raw_tick[2:0]}
                  & {4{ce_i}};

endmodule
`default_nettype wire

/* timer_array.sv */
// Notes on behaviour
// - Four channels, 32-bit counter and data each.
// - Data value is reload or compare per mode.
// - Shared prescaler gives four selectable count clocks.
// - Clocks zero to two divide by 2^0..2^15.
// - Clock three adds a fine non-power-of-two divider.
// - Group: one master, one slave (0 with 1, 2 with 3).
// - Independent channels ignore other channels entirely.
// - Master interrupt event starts and restarts its slaves.
// - Each group channel keeps its own mode.
// - Smaller index is upper, larger is lower.
// - Output mode: single channel or whole group.
// - Per-channel interrupt usable as wake-up.
// - System reset initializes all state.
// - Start by external input or by software.
// - Single peripheral clock drives all counts.
// - Count source: prescaler, master irq, input edge.
// - Software start sets counting-enabled flag.
// - After reset channels stopped, outputs low.
// - Only channels zero and two may master.
`timescale 1ns/1ps
`default_nettype none
module timer_array
  import timer_array_pkg::*;
#(
  parameter int unsigned CHANNELS = NUM_CHANNELS
)(
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  input  wire logic           ce_i,
  input  wire prescaler_cfg_t prescaler_cfg_i,
  input  wire channel_cfg_t   channel_cfg_i [CHANNELS],
  input  wire logic [3:0]     counter_start_trigger_bit_i,
  input  wire logic [3:0]     counter_stop_i,
  input  wire logic [3:0]     channel_timer_input_i,
  output logic [3:0]          counting_enabled_flag_o,
  output logic [3:0]          channel_irq_o,
  output logic [3:0]          channel_timer_output_o,
  output logic [31:0]         channel_counter_o [CHANNELS]
);

  // The channel structure is written for exactly four channels.
  if (CHANNELS != NUM_CHANNELS) begin : g_bad_channels
    $error("timer_array supports exactly four channels");
  end

  // Prescaled count clock ticks.
  logic [3:0]        prescaled_count_clocks;
  // Two-stage synchronizer for the timer inputs from the pins.
  logic [3:0]        in_meta;
  logic [3:0]        in_sync;
  logic [3:0]        in_prev;
  // Rising edge of each synchronized input.
  logic [3:0]        in_edge;
  // Channel states and counters.
  ch_state_t         state [4];
  logic [31:0]       channel_counter [4];
  // Per-channel count tick and start event.
  logic [3:0]        count_tick;
  logic [3:0]        start_evt;
  // Index of each channel's master.
  logic [1:0]        master_of [4];
  // Slave bit of each channel, honoured only where the channel may be a slave.
  logic [3:0]        slave_ok;
  // Terminal event of each channel, produced combinationally.
  logic [3:0]        terminal;
  // Registered interrupt pulses and outputs.
  logic [3:0]        irq;
  logic [3:0]        tout;

  // Prescaler shared by all channels.
  timer_prescaler u_prescaler (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .cfg_i  (prescaler_cfg_i),
    .tick_o (prescaled_count_clocks)
  );

  // Finds the nearest even upper channel that can act as master.
  function automatic logic [1:0] master_index(input int unsigned ch);
    logic [1:0] r;
    r = (ch >= 2) ? 2'h2 : 2'h0;
    return r;
  endfunction

  // Synchronize the filtered timer inputs before any logic reads them.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      in_meta <= 4'h0;
      in_sync <= 4'h0;
      in_prev <= 4'h0;
    end else if (ce_i) begin
      in_meta <= channel_timer_input_i;
      in_sync <= in_meta;
      in_prev <= in_sync;
    end
  end

  // Only a rising edge of the synchronized level counts as an input event.
  assign in_edge = in_sync & ~in_prev;

  // Select count tick and start event for each channel.
  always_comb begin
    for (int m = 0; m < 4; m++) begin
      master_of[m] = master_index(m);
      // A channel that is not a legal slave uses no other channel.
      slave_ok[m]  = channel_cfg_i[m].is_slave && (m != 0) && (m != 2);
      case (channel_cfg_i[m].clk_src)
        SRC_CK0:        count_tick[m] = prescaled_count_clocks[0];
        SRC_CK1:        count_tick[m] = prescaled_count_clocks[1];
        SRC_CK2:        count_tick[m] = prescaled_count_clocks[2];
        SRC_CK3:        count_tick[m] = prescaled_count_clocks[3];
        SRC_MASTER_IRQ: count_tick[m] = slave_ok[m] & irq[master_of[m]];
        SRC_INPUT_EDGE: count_tick[m] = in_edge[m];
        default:        count_tick[m] = 1'b0;
      endcase
      case (channel_cfg_i[m].trig)
        TRIG_SOFTWARE:   start_evt[m] = 1'b1;
        TRIG_INPUT_EDGE: start_evt[m] = in_edge[m];
        TRIG_MASTER_IRQ: start_evt[m] = slave_ok[m] & irq[master_of[m]];
        default:         start_evt[m] = 1'b0;
      endcase
      count_tick[m] = count_tick[m] & ce_i;
      start_evt[m]  = start_evt[m] & ce_i;
    end
  end

  // Terminal event: zero in interval mode, compare match in compare mode.
  always_comb begin
    for (int m = 0; m < 4; m++) begin
      if (channel_cfg_i[m].mode == MODE_INTERVAL_DOWN) begin
        terminal[m] = (state[m] == CH_COUNTING) && count_tick[m] &&
                      (channel_counter[m] == 32'h0000_0000);
      end else begin
        terminal[m] = (state[m] == CH_COUNTING) && count_tick[m] &&
                      (channel_counter[m] == channel_cfg_i[m].data_value);
      end
    end
  end

  // Channel state machines and counters.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int m = 0; m < 4; m++) begin
        state[m]           <= CH_STOPPED;
        channel_counter[m] <= COUNTER_RESET_VALUE;
      end
    end else if (ce_i) begin
      for (int m = 0; m < 4; m++) begin
        case (state[m])
          CH_STOPPED: begin
            if (counter_start_trigger_bit_i[m]) begin
              state[m] <= CH_WAITING;
            end
          end
          CH_WAITING: begin
            if (counter_stop_i[m]) begin
              state[m] <= CH_STOPPED;
            end else if (start_evt[m]) begin
              state[m] <= CH_COUNTING;
              channel_counter[m] <= (channel_cfg_i[m].mode == MODE_INTERVAL_DOWN) ?
                                    channel_cfg_i[m].data_value : 32'h0000_0000;
            end
          end
          CH_COUNTING: begin
            if (counter_stop_i[m]) begin
              state[m] <= CH_STOPPED;
            end else if ((channel_cfg_i[m].trig == TRIG_MASTER_IRQ) && start_evt[m]) begin
              // The master's event restarts the slave counter.
              channel_counter[m] <= (channel_cfg_i[m].mode == MODE_INTERVAL_DOWN) ?
                                    channel_cfg_i[m].data_value : 32'h0000_0000;
            end else if (terminal[m]) begin
              channel_counter[m] <= (channel_cfg_i[m].mode == MODE_INTERVAL_DOWN) ?
                                    channel_cfg_i[m].data_value : 32'h0000_0000;
            end else if (count_tick[m]) begin
              channel_counter[m] <= (channel_cfg_i[m].mode == MODE_INTERVAL_DOWN) ?
                                    channel_counter[m] - 32'h0000_0001 :
                                    channel_counter[m] + 32'h0000_0001;
            end
          end
          default: state[m] <= CH_STOPPED;
        endcase
      end
    end
  end

  // One-cycle interrupt pulses on each terminal event.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq <= 4'h0;
    end else if (ce_i) begin
      irq <= terminal;
    end else begin
      irq <= 4'h0;
    end
  end

  // Timer outputs toggle on their own event; in group output mode the master's event sets them high and their own clears them.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tout <= {4{OUTPUT_RESET_LEVEL}};
    end else if (ce_i) begin
      for (int m = 0; m < 4; m++) begin
        if (channel_cfg_i[m].sync_output && slave_ok[m]) begin
          if (irq[master_of[m]]) begin
            tout[m] <= 1'b1;
          end else if (terminal[m]) begin
            tout[m] <= 1'b0;
          end
        end else if (terminal[m]) begin
          tout[m] <= ~tout[m];
        end
      end
    end
  end

  // Status flags and counter values seen from outside.
  always_comb begin
    for (int m = 0; m < 4; m++) begin
      counting_enabled_flag_o[m] = (state[m] != CH_STOPPED);
      channel_counter_o[m]       = channel_counter[m];
    end
  end

  assign channel_irq_o          = irq;
  assign channel_timer_output_o = tout;

  // Assertions.
  a_irq_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    channel_irq_o[0] |=> !channel_irq_o[0])
    else $error("irq longer than one cycle");
  a_start_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && state[1] == CH_STOPPED && counter_start_trigger_bit_i[1]) |=>
    counting_enabled_flag_o[1])
    else $error("start did not set flag");
  a_irq_from_terminal: assert property (@(posedge clk_i) disable iff (rst_i)
    channel_irq_o[2] |-> $past(terminal[2]))
    else $error("irq without terminal event");
  a_stop_clears_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && counter_stop_i[3] && state[3] != CH_STOPPED) |=> !counting_enabled_flag_o[3])
    else $error("stop did not clear flag");
  a_interval_reload: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && terminal[0] && !counter_stop_i[0] && channel_cfg_i[0].trig != TRIG_MASTER_IRQ
     && channel_cfg_i[0].mode == MODE_INTERVAL_DOWN)
    |=> channel_counter_o[0] == $past(channel_cfg_i[0].data_value))
    else $error("interval reload wrong");
  a_count_down_step: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && state[0] == CH_COUNTING && count_tick[0] && !terminal[0] && !counter_stop_i[0]
     && channel_cfg_i[0].mode == MODE_INTERVAL_DOWN && channel_cfg_i[0].trig != TRIG_MASTER_IRQ)
    |=> channel_counter_o[0] == $past(channel_counter_o[0]) - 32'h0000_0001)
    else $error("down count step wrong");
  a_frozen_when_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(channel_counter_o[1]))
    else $error("counter moved with enable low");
  a_stopped_no_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    (state[3] == CH_STOPPED) |=> !channel_irq_o[3])
    else $error("irq from stopped channel");

  c_irq_seen: cover property (@(posedge clk_i) disable iff (rst_i) channel_irq_o[0]);
  c_slave_start: cover property (@(posedge clk_i) disable iff (rst_i)
    channel_cfg_i[1].is_slave && state[1] == CH_WAITING && start_evt[1]);
  c_output_high: cover property (@(posedge clk_i) disable iff (rst_i) channel_timer_output_o[2]);
  c_slave_restart: cover property (@(posedge clk_i) disable iff (rst_i)
    slave_ok[3] && state[3] == CH_COUNTING && start_evt[3]);

endmodule
`default_nettype wire

/* timer_pins_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Far side of the timer array: the filtered pins and the interrupt controller.
module timer_pins_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] level_req_i,
  input  wire logic [3:0] irq_i,
  output logic [3:0]      pin_o,
  output logic [7:0]      irq_count_o [4]
);
  // Pins move only at a clock edge, so the filtered level has no glitches.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_o <= 4'h0;
    end else begin
      pin_o <= level_req_i;
    end
  end

  // The interrupt controller counts every request pulse it sees.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        irq_count_o[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (irq_i[i]) begin
          irq_count_o[i] <= irq_count_o[i] + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* four_channel_timer_array_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
$display("mismatch %s expected %0h seen %0h", n, e, g); end end
module four_channel_timer_array_test;
  import timer_array_pkg::*;
  logic           clk_i;
  logic           rst_i;
  prescaler_cfg_t pcfg;
  channel_cfg_t   cfg [4];
  logic [3:0]     start;
  logic [3:0]     stop;
  logic [3:0]     level_req;
  logic [3:0]     pins;
  logic [3:0]     flags;
  logic [3:0]     irq;
  logic [3:0]     outs;
  logic [31:0]    counters [4];
  logic [7:0]     irq_count [4];
  logic [7:0]     snap;
  logic [31:0]    held;
  logic           ce;
  logic [31:0]    state;
  int             fails;
  int             samples_checked;
  int             per;
  int             n;
  int             d [4];
  int             e [4];
  int             fine;

  timer_array u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .prescaler_cfg_i(pcfg),
    .channel_cfg_i(cfg), .counter_start_trigger_bit_i(start), .counter_stop_i(stop),
    .channel_timer_input_i(pins), .counting_enabled_flag_o(flags), .channel_irq_o(irq),
    .channel_timer_output_o(outs), .channel_counter_o(counters));

  timer_pins_model u_far (.clk_i(clk_i), .rst_i(rst_i), .level_req_i(level_req),
    .irq_i(irq), .pin_o(pins), .irq_count_o(irq_count));

  // Next value of the fixed-seed xorshift sequence, reduced below lim.
  function automatic int rnd(int lim);
    state = state ^ (state << 13);
    state = state ^ (state >> 17);
    state = state ^ (state << 5);
    return int'(state % 32'(lim));
  endfunction

  // Cycles between two requests of a free-running channel.
  function automatic int period_of(int data, int ex, int fd);
    return (data + 1) * (1 << ex) * (fd + 1);
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Waits for a request pulse of one channel; a used-up bound ends the run.
  task automatic wait_irq(int ch, int bound, output int cnt);
    cnt = 0;
    do begin
      @(negedge clk_i);
      cnt++;
    end while (irq[ch] !== 1'b1 && cnt < bound);
    if (irq[ch] !== 1'b1) begin
      fails++;
      $display("mismatch irq wait expected 1 seen 0");
      conclude();
    end
  endtask

  // Measures the spacing of two requests and the output toggle between them.
  task automatic measure(int ch, logic chk_out, output int p);
    logic o1;
    int   c;
    wait_irq(ch, 4000, c);
    @(negedge clk_i);
    `CHK("irq width", 1'b0, irq[ch])
    @(negedge clk_i);
    o1 = outs[ch];
    wait_irq(ch, 4000, c);
    p = c + 2;
    repeat (2) @(negedge clk_i);
    if (chk_out) `CHK("output toggle", ~o1, outs[ch])
  endtask

  // Issues one-cycle start and stop requests at the rising edge.
  task automatic pulse(logic [3:0] go, logic [3:0] halt);
    @(posedge clk_i);
    start <= go;
    stop <= halt;
    @(posedge clk_i);
    start <= 4'h0;
    stop <= 4'h0;
    @(negedge clk_i);
  endtask

  // Everything must sit at its initial value.
  task automatic check_idle();
    `CHK("flags idle", 4'h0, flags)
    `CHK("outputs low", 4'h0, outs)
    `CHK("irq idle", 4'h0, irq)
    for (int i = 0; i < 4; i++) `CHK("counter idle", 32'h0000_0000, counters[i])
  endtask

  // Free-running clock of 8 ns.
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Main sequence.
  initial begin
    state = 32'h0000_53b5;
    fails = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    ce = 1'b1;
    start = 4'h0;
    stop = 4'h0;
    level_req = 4'h0;
    pcfg = '0;
    for (int i = 0; i < 4; i++) cfg[i] = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    check_idle();
    $display("test reset done");
    // All four channels free-run on different count clocks, in alternating modes.
    for (int i = 0; i < 4; i++) begin
      d[i] = 2 + rnd(6);
      e[i] = (i == 3) ? rnd(2) : rnd(3);
    end
    fine = rnd(3);
    @(posedge clk_i);
    pcfg <= '{exp0: 4'(e[0]), exp1: 4'(e[1]), exp2: 4'(e[2]), exp3: 4'(e[3]),
              fine_div: 8'(fine)};
    for (int i = 0; i < 4; i++) begin
      cfg[i] <= '{mode: op_mode_t'(i % 2), clk_src: count_src_t'(i), trig: TRIG_SOFTWARE,
                  is_slave: 1'b0, sync_output: 1'b0, data_value: 32'(d[i])};
    end
    pulse(4'hf, 4'h0);
    `CHK("flags set", 4'hf, flags)
    for (int i = 0; i < 4; i++) begin
      measure(i, 1'b1, per);
      `CHK("period", period_of(d[i], e[i], (i == 3) ? fine : 0), per)
      `CHK("counter bound", 1'b1, counters[i] <= 32'(d[i]))
    end
    pulse(4'h0, 4'hf);
    `CHK("flags clear", 4'h0, flags)
    repeat (2) @(negedge clk_i);
    snap = irq_count[0];
    repeat (64) @(negedge clk_i);
    `CHK("stopped quiet", snap, irq_count[0])
    $display("test free run done");
    // Channel three waits for a rising input edge before counting.
    @(posedge clk_i);
    cfg[3] <= '{mode: MODE_INTERVAL_DOWN, clk_src: SRC_CK0, trig: TRIG_INPUT_EDGE,
                is_slave: 1'b0, sync_output: 1'b0, data_value: 32'h0000_0003};
    pulse(4'h8, 4'h0);
    `CHK("edge flag", 1'b1, flags[3])
    snap = irq_count[3];
    repeat (40) @(negedge clk_i);
    `CHK("no start yet", snap, irq_count[3])
    @(posedge clk_i);
    level_req <= 4'h8;
    wait_irq(3, 64 << e[0], n);
    `CHK("edge start irq", 1'b1, irq[3])
    pulse(4'h0, 4'h8);
    $display("test edge start done");
    // Channel one counts the requests of master zero; channel three restarts on master two.
    @(posedge clk_i);
    level_req <= 4'h0;
    cfg[0] <= '{mode: MODE_INTERVAL_DOWN, clk_src: SRC_CK0, trig: TRIG_SOFTWARE,
                is_slave: 1'b0, sync_output: 1'b0, data_value: 32'(d[0])};
    cfg[1] <= '{mode: MODE_INTERVAL_DOWN, clk_src: SRC_MASTER_IRQ, trig: TRIG_SOFTWARE,
                is_slave: 1'b1, sync_output: 1'b0, data_value: 32'(d[1])};
    cfg[2] <= '{mode: MODE_INTERVAL_DOWN, clk_src: SRC_CK0, trig: TRIG_SOFTWARE,
                is_slave: 1'b0, sync_output: 1'b0, data_value: 32'(d[2])};
    cfg[3] <= '{mode: MODE_COMPARE_UP, clk_src: SRC_CK0, trig: TRIG_MASTER_IRQ,
                is_slave: 1'b1, sync_output: 1'b1, data_value: 32'h0000_0001};
    pulse(4'hf, 4'h0);
    measure(1, 1'b1, per);
    `CHK("slave period", period_of(d[0], e[0], 0) * (d[1] + 1), per)
    wait_irq(2, 4000, n);
    wait_irq(2, 4000, n);
    `CHK("group output low", 1'b0, outs[3])
    @(negedge clk_i);
    `CHK("slave restart", 32'h0000_0000, counters[3])
    `CHK("group output high", 1'b1, outs[3])
    $display("test master slave done");
    // A low clock enable freezes the counters and silences the requests.
    @(posedge clk_i);
    ce <= 1'b0;
    @(negedge clk_i);
    held = counters[2];
    repeat (20) @(negedge clk_i);
    `CHK("frozen counter", held, counters[2])
    `CHK("frozen irq", 4'h0, irq)
    @(posedge clk_i);
    ce <= 1'b1;
    $display("test clock enable done");
    // A reset in mid-count returns everything to its initial state.
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(negedge clk_i);
    check_idle();
    @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(negedge clk_i);
    check_idle();
    $display("test second reset done");
    conclude();
  end
endmodule
`default_nettype wire
